/* include/mlc_cfg.svh */
// Register offsets, field positions, defaults and timing counts of the link block.
`ifndef MLC_CFG_SVH
`define MLC_CFG_SVH
`define MLC_OFF_CTRL 12'h000
`define MLC_OFF_PROTO 12'h004
`define MLC_OFF_AREA 12'h008
`define MLC_OFF_STUP 12'h00C
`define MLC_OFF_STDN 12'h010
`define MLC_OFF_SER 12'h014
`define MLC_OFF_SWAIT 12'h018
`define MLC_OFF_RWAIT 12'h01C
`define MLC_OFF_TXD 12'h020
`define MLC_OFF_STS 12'h024
`define MLC_OFF_MASK 12'h028
`define MLC_OFF_IDX 12'h02C
`define MLC_OFF_ADDR 12'h030
`define MLC_OFF_STATE 12'h034
`define MLC_SER_BAUD 2:0
`define MLC_SER_DLEN 3
`define MLC_SER_PAR 5:4
`define MLC_SER_STOP 6
`define MLC_AREA_DN 7:4
`define MLC_AREA_UP 3:0
`define MLC_ST_SENT 0
`define MLC_ST_RESP 1
`define MLC_ST_TMO 2
`define MLC_ST_CFG 3
`define MLC_ST_ADDR 4
`define MLC_PROTO_1N 3'h2
`define MLC_PROTO_CMN 3'h4
`define MLC_PROTO_F5 3'h5
`define MLC_DEF_PROTO 3'h2
`define MLC_DEF_AREA 8'h00
`define MLC_DEF_STUP 15'h0000
`define MLC_DEF_STDN 15'd500
`define MLC_DEF_SER 7'h1F
`define MLC_DEF_SWAIT 7'd5
`define MLC_DEF_RWAIT 14'd2000
`define MLC_MAX_EM 4'd13
`define MLC_MAX_SWAIT 7'd99
`define MLC_MIN_RWAIT 14'd10
`define MLC_MAX_RWAIT 14'd10000
`define MLC_LIM_WIDE 17'd32767
`define MLC_LIM_DREG 17'd12287
`define MLC_LIM_LREG 17'h0_1FFF
`define MLC_CLK_HZ 10000000
`define MLC_CLK_NS 100
`define MLC_MS_NS 1000000
`define MLC_DIV(b) 16'((`MLC_CLK_HZ + (b) / 2) / (b))
`endif

/* include/mlc_pkg.sv */
// Types shared by the link block modules.
package mlc_pkg;
    typedef enum logic [3:0] {
        MLC_IDLE = 4'b0001,
        MLC_WAIT = 4'b0010,
        MLC_SEND = 4'b0100,
        MLC_RESP = 4'b1000
    } mlc_state_t;
    typedef enum logic [1:0] {
        MLC_K_PRIMARY = 2'h0,
        MLC_K_BANK = 2'h1,
        MLC_K_LINK = 2'h2,
        MLC_K_FILE = 2'h3
    } mlc_kind_t;
endpackage

/* include/mlc_ser_if.sv */
// Character request and framing settings passed to the serial transmitter.
`timescale 1ns/1ns
interface mlc_ser_if;
    logic [15:0] div;
    logic dlen8;
    logic [1:0] par;
    logic stop2;
    logic [7:0] data;
    logic go;
    logic busy;
    logic done;
    logic txd;
    modport ctl (output div, dlen8, par, stop2, data, go, input busy, done, txd);
    modport tx (input div, dlen8, par, stop2, data, go, output busy, done, txd);
endinterface

/* hw/mlc_ser_tx.sv */
// Serial character transmitter with selectable length, parity and stop bits.
`timescale 1ns/1ns
module mlc_ser_tx (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Character request.
    mlc_ser_if.tx ser
);
    logic [11:0] frame_ff;
    logic [3:0] left_ff;
    logic [15:0] baud_ff;
    logic busy_ff;
    logic done_ff;
    logic [15:0] div_ff;
    logic pbit;
    logic [11:0] nxt_frame;
    logic [3:0] nxt_left;

    // Frame is built low bit first; spare high bits are idle ones.
    always_comb begin
        pbit = (ser.dlen8 ? ^ser.data : ^ser.data[6:0]) ^ (ser.par == 2'h2);
        if (ser.par == 2'h0) begin
            pbit = 1'b1;
        end
        nxt_frame = ser.dlen8 ? {2'b11, pbit, ser.data, 1'b0}
                              : {3'b111, pbit, ser.data[6:0], 1'b0};
        nxt_left = 4'd9 + {3'b000, ser.dlen8} + {3'b000, ser.par != 2'h0}
                   + {3'b000, ser.stop2};
    end

    // Shift one bit per baud period.
    always_ff @(posedge clk) begin
        done_ff <= 1'b0;
        if (sys_rst) begin
            frame_ff <= 12'hFFF;
            left_ff <= 4'h0;
            baud_ff <= 16'h0000;
            busy_ff <= 1'b0;
            div_ff <= 16'h0001;
        end else if (!busy_ff) begin
            if (ser.go) begin
                frame_ff <= nxt_frame;
                left_ff <= nxt_left;
                div_ff <= ser.div;
                baud_ff <= 16'h0000;
                busy_ff <= 1'b1;
            end
        end else if (baud_ff == div_ff - 16'h0001) begin
            baud_ff <= 16'h0000;
            frame_ff <= {1'b1, frame_ff[11:1]};
            left_ff <= left_ff - 4'h1;
            if (left_ff == 4'h1) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
        end else begin
            baud_ff <= baud_ff + 16'h0001;
        end
    end

    // Spare frame bits and shifted-in bits are ones, so the flop idles high by itself.
    assign ser.txd = frame_ff[0];
    assign ser.busy = busy_ff;
    assign ser.done = done_ff;
endmodule

/* hw/mlc_link_top.sv */
// Link configuration registers, command timing and serial framing for the controller link.
`timescale 1ns/1ns
`include "mlc_cfg.svh"
module mlc_link_top #(
    parameter int CYC_PER_MS = `MLC_MS_NS / `MLC_CLK_NS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // AXI4-Lite write channels.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial link to the controller.
    output logic txd,
    input wire logic rxd,
    // Interrupt.
    output logic irq
);
    mlc_ser_if ser ();
    mlc_pkg::mlc_state_t state_ff;
    logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff, arready_ff, irq_ff, apply_ff, txgo_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff, nxt_rdata, idx_ff, addr_ff;
    logic [2:0] proto_pd_ff, proto_act_ff;
    logic [7:0] area_pd_ff, area_act_ff, txbyte_ff;
    logic [14:0] stup_pd_ff, stdn_pd_ff, stup_act_ff, stdn_act_ff;
    logic [6:0] ser_pd_ff, ser_act_ff, swait_pd_ff, swait_act_ff, ser_eff, swait_eff;
    logic [13:0] rwait_pd_ff, rwait_act_ff, rwait_eff;
    logic [4:0] sts_ff, mask_ff, sts_set;
    logic [15:0] pre_ff;
    logic [13:0] ms_ff;
    logic do_wr, pd_ok, up_ok, dn_ok;
    logic [16:0] sum_up, sum_dn;

    // Upper address bound of an area for a protocol; zero marks an invalid code.
    function automatic logic [16:0] area_lim(input logic [2:0] pr, input logic [3:0] ar);
        logic [16:0] l;
        l = 17'h0_0000;
        if (pr == `MLC_PROTO_1N) begin
            if (ar <= `MLC_MAX_EM) begin
                l = `MLC_LIM_WIDE;
            end
        end else if (ar == 4'h0) begin
            l = `MLC_LIM_DREG;
        end else if (ar == 4'h1) begin
            l = `MLC_LIM_LREG;
        end else if (ar == 4'h2) begin
            l = `MLC_LIM_WIDE;
        end
        return l;
    endfunction

    // Kind of memory area the code selects under the active protocol.
    function automatic mlc_pkg::mlc_kind_t area_kind(input logic [3:0] ar);
        mlc_pkg::mlc_kind_t k;
        k = mlc_pkg::MLC_K_PRIMARY;
        if (proto_act_ff == `MLC_PROTO_1N) begin
            k = (ar == 4'h0) ? mlc_pkg::MLC_K_PRIMARY : mlc_pkg::MLC_K_BANK;
        end else if (ar == 4'h1) begin
            k = mlc_pkg::MLC_K_LINK;
        end else if (ar == 4'h2) begin
            k = mlc_pkg::MLC_K_FILE;
        end
        return k;
    endfunction

    // Whole pending set must be legal; a bad set leaves the old one in force.
    always_comb begin
        pd_ok = (proto_pd_ff == `MLC_PROTO_1N) || (proto_pd_ff == `MLC_PROTO_CMN)
                || (proto_pd_ff == `MLC_PROTO_F5);
        pd_ok = pd_ok && (area_lim(proto_pd_ff, area_pd_ff[`MLC_AREA_UP]) != 17'h0_0000)
                && (area_lim(proto_pd_ff, area_pd_ff[`MLC_AREA_DN]) != 17'h0_0000)
                && ({2'b00, stup_pd_ff} <= area_lim(proto_pd_ff, area_pd_ff[`MLC_AREA_UP]))
                && ({2'b00, stdn_pd_ff} <= area_lim(proto_pd_ff, area_pd_ff[`MLC_AREA_DN]));
        pd_ok = pd_ok && (ser_pd_ff[`MLC_SER_BAUD] >= 3'h3) && (ser_pd_ff[`MLC_SER_PAR] != 2'h3)
                && (swait_pd_ff <= `MLC_MAX_SWAIT) && (rwait_pd_ff >= `MLC_MIN_RWAIT)
                && (rwait_pd_ff <= `MLC_MAX_RWAIT);
    end

    // The 1:N protocol ignores framing and timing settings.
    always_comb begin
        if (proto_act_ff == `MLC_PROTO_1N) begin
            ser_eff = `MLC_DEF_SER;
            swait_eff = `MLC_DEF_SWAIT;
            rwait_eff = `MLC_DEF_RWAIT;
        end else begin
            ser_eff = ser_act_ff;
            swait_eff = swait_act_ff;
            rwait_eff = rwait_act_ff;
        end
        case (ser_eff[`MLC_SER_BAUD])
            3'h3: ser.div = `MLC_DIV(9600);
            3'h4: ser.div = `MLC_DIV(19200);
            3'h5: ser.div = `MLC_DIV(38400);
            3'h6: ser.div = `MLC_DIV(57600);
            default: ser.div = `MLC_DIV(115200);
        endcase
    end

    assign ser.dlen8 = ser_eff[`MLC_SER_DLEN];
    assign ser.par = ser_eff[`MLC_SER_PAR];
    assign ser.stop2 = ser_eff[`MLC_SER_STOP];
    assign ser.data = txbyte_ff;
    assign ser.go = (state_ff == mlc_pkg::MLC_WAIT) && (ms_ff >= {7'h00, swait_eff});

    mlc_ser_tx u_tx (
        .clk(clk),
        .sys_rst(sys_rst),
        .ser(ser)
    );

    // Write address and data are taken in either order; the response follows both.
    assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && !aw_ok_ff) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ok_ff) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
            end
        end
    end

    // Pending settings; the byte strobes are honoured as whole-word writes.
    always_ff @(posedge clk) begin
        apply_ff <= 1'b0;
        txgo_ff <= 1'b0;
        if (sys_rst) begin
            proto_pd_ff <= `MLC_DEF_PROTO;
            area_pd_ff <= `MLC_DEF_AREA;
            stup_pd_ff <= `MLC_DEF_STUP;
            stdn_pd_ff <= `MLC_DEF_STDN;
            ser_pd_ff <= `MLC_DEF_SER;
            swait_pd_ff <= `MLC_DEF_SWAIT;
            rwait_pd_ff <= `MLC_DEF_RWAIT;
            mask_ff <= 5'h00;
            idx_ff <= 32'h0000_0000;
            txbyte_ff <= 8'h00;
        end else if (do_wr && (s_axi_wstrb != 4'h0)) begin
            case (awaddr_ff)
                `MLC_OFF_CTRL: apply_ff <= wdata_ff[0];
                `MLC_OFF_PROTO: proto_pd_ff <= wdata_ff[2:0];
                `MLC_OFF_AREA: area_pd_ff <= wdata_ff[7:0];
                `MLC_OFF_STUP: stup_pd_ff <= wdata_ff[14:0];
                `MLC_OFF_STDN: stdn_pd_ff <= wdata_ff[14:0];
                `MLC_OFF_SER: ser_pd_ff <= wdata_ff[6:0];
                `MLC_OFF_SWAIT: swait_pd_ff <= wdata_ff[6:0];
                `MLC_OFF_RWAIT: rwait_pd_ff <= wdata_ff[13:0];
                `MLC_OFF_MASK: mask_ff <= wdata_ff[4:0];
                `MLC_OFF_IDX: idx_ff <= wdata_ff;
                `MLC_OFF_TXD: begin
                    txbyte_ff <= wdata_ff[7:0];
                    txgo_ff <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // Active settings change only on apply, and only when the whole set is legal.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            proto_act_ff <= `MLC_DEF_PROTO;
            area_act_ff <= `MLC_DEF_AREA;
            stup_act_ff <= `MLC_DEF_STUP;
            stdn_act_ff <= `MLC_DEF_STDN;
            ser_act_ff <= `MLC_DEF_SER;
            swait_act_ff <= `MLC_DEF_SWAIT;
            rwait_act_ff <= `MLC_DEF_RWAIT;
        end else if (apply_ff && pd_ok) begin
            proto_act_ff <= proto_pd_ff;
            area_act_ff <= area_pd_ff;
            stup_act_ff <= stup_pd_ff;
            stdn_act_ff <= stdn_pd_ff;
            ser_act_ff <= ser_pd_ff;
            swait_act_ff <= swait_pd_ff;
            rwait_act_ff <= rwait_pd_ff;
        end
    end

    // Word address is start plus word index; a direction past its area keeps its old address.
    assign sum_up = {2'b00, stup_act_ff} + {1'b0, idx_ff[15:0]};
    assign sum_dn = {2'b00, stdn_act_ff} + {1'b0, idx_ff[31:16]};
    assign up_ok = sum_up <= area_lim(proto_act_ff, area_act_ff[`MLC_AREA_UP]);
    assign dn_ok = sum_dn <= area_lim(proto_act_ff, area_act_ff[`MLC_AREA_DN]);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_ff <= 32'h0000_0000;
        end else begin
            if (up_ok) begin
                addr_ff[15:0] <= sum_up[15:0];
            end
            if (dn_ok) begin
                addr_ff[31:16] <= sum_dn[15:0];
            end
        end
    end

    // Millisecond prescaler runs only while a wait is being timed.
    always_ff @(posedge clk) begin
        if (sys_rst || (state_ff == mlc_pkg::MLC_IDLE) || (state_ff == mlc_pkg::MLC_SEND)) begin
            pre_ff <= 16'h0000;
            ms_ff <= 14'h0000;
        end else if (pre_ff == 16'(CYC_PER_MS - 1)) begin
            pre_ff <= 16'h0000;
            ms_ff <= ms_ff + 14'h0001;
        end else begin
            pre_ff <= pre_ff + 16'h0001;
        end
    end

    // Command sequence: send wait, character out, then wait for the reply start bit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= mlc_pkg::MLC_IDLE;
        end else begin
            case (state_ff)
                mlc_pkg::MLC_IDLE: if (txgo_ff) state_ff <= mlc_pkg::MLC_WAIT;
                mlc_pkg::MLC_WAIT: if (ser.go) state_ff <= mlc_pkg::MLC_SEND;
                mlc_pkg::MLC_SEND: if (ser.done) state_ff <= mlc_pkg::MLC_RESP;
                mlc_pkg::MLC_RESP: begin
                    if (!rxd || (ms_ff >= rwait_eff)) begin
                        state_ff <= mlc_pkg::MLC_IDLE;
                    end
                end
                default: state_ff <= mlc_pkg::MLC_IDLE;
            endcase
        end
    end

    // Sticky events; a set in the clearing cycle survives the clear.
    always_comb begin
        sts_set = 5'h00;
        sts_set[`MLC_ST_SENT] = ser.done;
        sts_set[`MLC_ST_RESP] = (state_ff == mlc_pkg::MLC_RESP) && !rxd;
        sts_set[`MLC_ST_TMO] = (state_ff == mlc_pkg::MLC_RESP) && rxd && (ms_ff >= rwait_eff);
        sts_set[`MLC_ST_CFG] = apply_ff && !pd_ok;
        sts_set[`MLC_ST_ADDR] = !up_ok || !dn_ok;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sts_ff <= 5'h00;
            irq_ff <= 1'b0;
        end else begin
            if (do_wr && (awaddr_ff == `MLC_OFF_STS)) begin
                sts_ff <= (sts_ff & ~wdata_ff[4:0]) | sts_set;
            end else begin
                sts_ff <= sts_ff | sts_set;
            end
            irq_ff <= |(sts_ff & mask_ff);
        end
    end

    // Read data path; unmapped words read as zero with an OKAY answer.
    always_comb begin
        case (s_axi_araddr)
            `MLC_OFF_PROTO: nxt_rdata = {29'h0, proto_pd_ff};
            `MLC_OFF_AREA: nxt_rdata = {24'h0, area_pd_ff};
            `MLC_OFF_STUP: nxt_rdata = {17'h0, stup_pd_ff};
            `MLC_OFF_STDN: nxt_rdata = {17'h0, stdn_pd_ff};
            `MLC_OFF_SER: nxt_rdata = {25'h0, ser_pd_ff};
            `MLC_OFF_SWAIT: nxt_rdata = {25'h0, swait_pd_ff};
            `MLC_OFF_RWAIT: nxt_rdata = {18'h0, rwait_pd_ff};
            `MLC_OFF_STS: nxt_rdata = {27'h0, sts_ff};
            `MLC_OFF_MASK: nxt_rdata = {27'h0, mask_ff};
            `MLC_OFF_IDX: nxt_rdata = idx_ff;
            `MLC_OFF_ADDR: nxt_rdata = addr_ff;
            `MLC_OFF_STATE: nxt_rdata = {12'h0, 2'(area_kind(area_act_ff[`MLC_AREA_DN])),
                                         2'(area_kind(area_act_ff[`MLC_AREA_UP])),
                                         area_act_ff, state_ff, 1'b0, proto_act_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            arready_ff <= 1'b0;
            if (s_axi_arvalid && !arready_ff && !rvalid_ff) begin
                arready_ff <= 1'b1;
                rvalid_ff <= 1'b1;
                rdata_ff <= nxt_rdata;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_ok_ff;
    assign s_axi_wready = !w_ok_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = 2'b00;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = 2'b00;
    assign txd = ser.txd;
    assign irq = irq_ff;

    sequence s_go;
        state_ff == mlc_pkg::MLC_WAIT && ser.go;
    endsequence
    sequence s_tx_start;
        ##1 ser.busy ##1 !txd;
    endsequence
    property p_hold;
        @(posedge clk) disable iff (sys_rst) !apply_ff |=> $stable(proto_act_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("active protocol changed without apply");
    property p_proto;
        @(posedge clk) disable iff (sys_rst)
            proto_act_ff inside {`MLC_PROTO_1N, `MLC_PROTO_CMN, `MLC_PROTO_F5};
    endproperty
    a_proto: assert property (p_proto) else $error("illegal active protocol");
    property p_start;
        @(posedge clk) disable iff (sys_rst)
            {2'b00, stdn_act_ff} <= area_lim(proto_act_ff, area_act_ff[`MLC_AREA_DN]);
    endproperty
    a_start: assert property (p_start) else $error("download start out of range");
    property p_wait;
        @(posedge clk) disable iff (sys_rst)
            state_ff == mlc_pkg::MLC_WAIT && ms_ff < {7'h00, swait_eff}
            |=> state_ff == mlc_pkg::MLC_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("sent before send wait");
    property p_frame;
        @(posedge clk) disable iff (sys_rst) s_go |-> s_tx_start;
    endproperty
    a_frame: assert property (p_frame) else $error("no start bit after go");
    property p_tmo;
        @(posedge clk) disable iff (sys_rst)
            (state_ff == mlc_pkg::MLC_RESP && rxd && ms_ff >= rwait_eff)
            |=> sts_ff[`MLC_ST_TMO] && state_ff == mlc_pkg::MLC_IDLE;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not flagged");
    property p_def;
        @(posedge clk) disable iff (sys_rst)
            proto_act_ff == `MLC_PROTO_1N |-> ser.div == `MLC_DIV(115200) && rwait_eff == 14'd2000;
    endproperty
    a_def: assert property (p_def) else $error("1:N link not using defaults");
    property p_bad;
        @(posedge clk) disable iff (sys_rst)
            apply_ff && !pd_ok |=> $stable(stup_act_ff) && sts_ff[`MLC_ST_CFG];
    endproperty
    a_bad: assert property (p_bad) else $error("illegal set took effect");
    property p_irq;
        @(posedge clk) disable iff (sys_rst) |(sts_ff & mask_ff) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

/* dv/mlc_plc_model.sv */
// Controller serial port model: decodes one character and may answer it.
`timescale 1ns/1ns
module mlc_plc_model (
    // Clock.
    input wire logic clk,
    // Serial lines.
    input wire logic txd,
    output logic rxd,
    // Control and observation.
    input wire logic respond,
    input wire logic [15:0] bit_cyc,
    output logic [7:0] got,
    output logic got_par,
    output int got_cnt
);
    // The line is pulled up, so a released line reads high.
    initial begin
        rxd = 1'b1;
        got = 8'h00;
        got_par = 1'b0;
        got_cnt = 0;
    end
    // Sample mid-cell, LSB first; answer shortly after the stop bit.
    always begin
        @(negedge txd);
        repeat (bit_cyc + bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            got[i] = txd;
            repeat (bit_cyc) @(posedge clk);
        end
        // The ninth cell is the parity bit when parity is on.
        got_par = txd;
        repeat (bit_cyc + bit_cyc / 2 + 10) @(posedge clk);
        got_cnt++;
        if (respond) begin
            rxd <= 1'b0;
            repeat (bit_cyc) @(posedge clk);
            rxd <= 1'b1;
        end
    end
endmodule

/* dv/plc_memory_link_config_tb.sv */
// Self-checking bench of the link block over its register bus and serial line.
`timescale 1ns/1ns
`include "mlc_cfg.svh"
module plc_memory_link_config_tb;
    localparam int BIT_CYC = (10_000_000 + 57_600) / 115_200;
    localparam int BIT_SLOW = (10_000_000 + 28_800) / 57_600;
    logic [15:0] bit_cyc = 16'(BIT_CYC);
    logic got_par;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] aw = 12'h000, ar = 12'h000;
    logic [31:0] wd = 32'h0000_0000;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, respond = 1'b0;
    logic awr, wr_r, bv, arr, rv, txd, rxd, irq;
    logic [1:0] br, rr;
    logic [31:0] rdat;
    logic [7:0] got;
    int got_cnt, mismatches = 0, checks_done = 0;
    logic [31:0] exp_q[$];
    string nam_q[$];
    logic [31:0] defs [7] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_01F4,
        32'h0000_001F, 32'h0000_0005, 32'h0000_07D0};
    mlc_link_top #(.CYC_PER_MS(10)) i_mlc_link_top (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .txd(txd), .rxd(rxd), .irq(irq));
    mlc_plc_model i_mlc_plc_model (.clk(clk), .txd(txd), .rxd(rxd), .respond(respond),
        .bit_cyc(bit_cyc), .got(got), .got_par(got_par), .got_cnt(got_cnt));
    // Free-running system clock.
    initial forever #50 clk = ~clk;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task hung;
        mismatches++;
        end_of_test();
    endtask
    // Each channel is released at the edge that takes it.
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
            if (bv) break;
        end
        bry <= 1'b0;
        if (n == 40) hung();
        // Let an edge pass so the next call never re-raises a strobe in this step.
        @(posedge clk);
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        int n;
        exp_q.push_back(e);
        nam_q.push_back(nm);
        ar <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rry <= 1'b0;
        if (n == 40) hung();
        @(posedge clk);
    endtask
    task wait_char;
        int n, c0;
        c0 = got_cnt;
        for (n = 0; n < 3000 && got_cnt == c0; n++) @(posedge clk);
        if (n == 3000) hung();
    endtask
    // Read data is compared with the oldest noted expectation.
    always @(posedge clk) begin
        if (rv && rry && exp_q.size() > 0) chk(nam_q.pop_front(), exp_q.pop_front(), rdat);
    end
    // Main sequence.
    initial begin
        int u, d, c;
        u = $urandom(58);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd("default", 12'(4 * i + 4), defs[i]);
        end
        rd("unmapped", 12'h3F0, 32'h0000_0000);
        wr(`MLC_OFF_MASK, 32'h0000_001F);
        wr(`MLC_OFF_PROTO, 32'h0000_0003);
        wr(`MLC_OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        rd("reject", `MLC_OFF_STS, 32'h0000_0008);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wr(`MLC_OFF_STS, 32'h0000_0008);
        rd("cleared", `MLC_OFF_STS, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wr(`MLC_OFF_PROTO, 32'h0000_0004);
        wr(`MLC_OFF_AREA, 32'h0000_0021);
        wr(`MLC_OFF_STUP, 32'h0000_0064);
        wr(`MLC_OFF_STDN, 32'h0000_03E8);
        wr(`MLC_OFF_SWAIT, 32'h0000_0000);
        wr(`MLC_OFF_RWAIT, 32'h0000_000A);
        rd("held", `MLC_OFF_STATE, 32'h0000_0012);
        wr(`MLC_OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        rd("active", `MLC_OFF_STATE, 32'h000E_2114);
        u = $urandom % 100;
        d = $urandom % 100;
        wr(`MLC_OFF_IDX, {16'(d), 16'(u)});
        rd("addr", `MLC_OFF_ADDR, {16'(1000 + d), 16'(100 + u)});
        respond <= 1'b1;
        c = $urandom % 256;
        wr(`MLC_OFF_TXD, 32'(c));
        wait_char();
        chk("char", 32'(c), {24'h0, got});
        chk("even parity", {31'h0, ^c[7:0]}, {31'h0, got_par});
        repeat (200) @(posedge clk);
        rd("reply", `MLC_OFF_STS, 32'h0000_0003);
        wr(`MLC_OFF_STS, 32'h0000_0003);
        respond <= 1'b0;
        wr(`MLC_OFF_TXD, 32'h0000_0055);
        wait_char();
        repeat (300) @(posedge clk);
        rd("timeout", `MLC_OFF_STS, 32'h0000_0005);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        // Slower rate, odd parity and two stop bits after a third apply.
        bit_cyc <= 16'(BIT_SLOW);
        wr(`MLC_OFF_SER, 32'h0000_006E);
        wr(`MLC_OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        c = $urandom % 256;
        wr(`MLC_OFF_TXD, 32'(c));
        wait_char();
        chk("slow char", 32'(c), {24'h0, got});
        chk("odd parity", {31'h0, ~^c[7:0]}, {31'h0, got_par});
        end_of_test();
    end
endmodule
